// ---- design/rap_regs.vh ----
// Register offsets, field positions, reset values and constants
`ifndef RAP_REGS_VH
`define RAP_REGS_VH

`define RAP_ADDR_ACC_MODE 8'h00
`define RAP_ADDR_LC_MODE 8'h01
`define RAP_ADDR_COMP_MODE 8'h02
`define RAP_ADDR_HALFCYC 8'h03
`define RAP_ADDR_MASK 8'h04
`define RAP_ADDR_STATUS 8'h05
`define RAP_ADDR_GAIN_BASE 8'h06
`define RAP_ADDR_NOM_V 8'h09
`define RAP_ADDR_VAR_BASE 8'h10
`define RAP_ADDR_VA_BASE 8'h18
`define RAP_ADDR_B_RMS 8'h1B

`define RAP_WIRE_HI 5
`define RAP_WIRE_LO 4
`define RAP_FMODE_HI 3
`define RAP_FMODE_LO 2
`define RAP_LC_VAR_BIT 1
`define RAP_ZX_SEL_HI 5
`define RAP_ZX_SEL_LO 3
`define RAP_RD_CLR_BIT 6
`define RAP_VNOMEN_HI 13
`define RAP_VNOMEN_LO 11
`define RAP_TERMSEL_HI 2
`define RAP_TERMSEL_LO 0
`define RAP_LDONE_BIT 5

`define RAP_WIRE_4W 2'h0
`define RAP_WIRE_3W 2'h1
`define RAP_WIRE_NEG_AC 2'h2
`define RAP_WIRE_NEG_A 2'h3
`define RAP_FMODE_SIGNED 2'h0
`define RAP_FMODE_SADJ 2'h1
`define RAP_FMODE_ABS 2'h2

`define RAP_RST_ACC_MODE 8'h00
`define RAP_RST_LC_MODE 8'h00
`define RAP_RST_COMP_MODE 16'h0007
`define RAP_RST_HALFCYC 16'hFFFF
`define RAP_RST_MASK 32'h00000000

`define RAP_FS_POWER 25'h1FF6A6B
`define RAP_RMS_FS 24'h3FF6A6
`define RAP_VA_SHIFT 4
`define RAP_GAIN_ONE 29'h0800000
`define RAP_GAIN_FRAC 23

`endif

// ---- design/rap_vaphase.v ----
// One phase of apparent power: rms product, nominal-voltage option, gain
`timescale 1ns/10ps
`default_nettype none
`include "rap_regs.vh"
module rap_vaphase (
  input wire core_clk,
  input wire nrst,
  input wire sample_strobe,
  input wire nom_v_en,
  input wire [23:0] v_rms,
  input wire [23:0] i_rms,
  input wire [23:0] nom_v,
  input wire [23:0] gain,
  output reg [23:0] va_out
);
  localparam [63:0] FS_SQ = {40'h0, `RAP_RMS_FS} * {40'h0, `RAP_RMS_FS};
  localparam [63:0] NORM_DEN = FS_SQ << `RAP_VA_SHIFT;

  // Negative nominal voltage makes no sense for a magnitude, so it clamps
  wire [23:0] v_used;
  assign v_used = nom_v_en ? (nom_v[23] ? 24'h000000 : nom_v) :
    v_rms;
  wire [47:0] vi;
  assign vi = v_used * i_rms;
  wire [79:0] scaled;
  assign scaled = {32'h0, vi} * {55'h0, `RAP_FS_POWER};
  wire [79:0] norm;
  assign norm = scaled / {16'h0, NORM_DEN};
  wire [28:0] gain_mul;
  assign gain_mul = {{5{gain[23]}}, gain} + `RAP_GAIN_ONE;
  wire signed [54:0] prod;
  assign prod = $signed({1'b0, norm[24:0]}) * $signed(gain_mul);
  wire signed [54:0] shifted;
  assign shifted = prod >>> `RAP_GAIN_FRAC;

  // No offset term anywhere in this path
  reg [23:0] va_next;
  always @* begin
    if (shifted < 0)
      va_next = 24'h000000;
    else if (shifted > 55'sh7FFFFF)
      va_next = 24'h7FFFFF;
    else
      va_next = shifted[23:0];
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      va_out <= 24'h000000;
    else if (sample_strobe)
      va_out <= va_next;
  end
endmodule // rap_vaphase
`default_nettype wire

// ---- design/rap_half_cycle_count.v ----
// Half-line-cycle counter over selected zero crossings
`timescale 1ns/10ps
`default_nettype none
`include "rap_regs.vh"
module rap_half_cycle_count #(
  parameter CW = 16
) (
  input wire core_clk,
  input wire nrst,
  input wire enable,
  input wire [2:0] zx_pulse,
  input wire [2:0] zx_sel,
  input wire [CW-1:0] count,
  output reg done
);
  function [1:0] popcnt3;
    input [2:0] v;
    begin
      popcnt3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
    end
  endfunction

  reg [CW-1:0] remain_reg;
  wire [1:0] dec;
  assign dec = popcnt3(zx_pulse & zx_sel);
  wire [CW-1:0] dec_w;
  assign dec_w = {{(CW-2){1'b0}}, dec};

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      remain_reg <= {CW{1'b1}};
      done <= 1'b0;
    end else if (!enable) begin
      // Idle: keep primed so a period starts clean when enabled
      remain_reg <= count;
      done <= 1'b0;
    end else if (dec != 2'h0 && remain_reg <= dec_w) begin
      remain_reg <= count;
      done <= 1'b1;
    end else begin
      remain_reg <= remain_reg - dec_w;
      done <= 1'b0;
    end
  end
endmodule // rap_half_cycle_count
`default_nettype wire

// ---- design/rap_core.v ----
// Reactive accumulation mode control and per-phase apparent power
//
// Functional notes
// - Wiring field picks phase B voltage source
// - Three-wire: line A-C rms into B rms
// - Var-hours signed; frequency output mode selectable
// - Line-cycle enable bit syncs reactive accumulation
// - Transfer accumulators after programmed half-cycle count
// - Zero-cross select picks any phase combination
// - Apparent power is voltage rms times current rms
// - Normalized product times full-scale constant over 16
// - Apparent power results are 24-bit waveforms
// - Gain scales by one plus gain/2^23
// - Gain C00000 halves, 400000 adds half
// - Gain read with zero top byte, sign extended to 29 bits internally
// - No apparent power offset correction
// - Nominal enable substitutes nominal voltage register
// - Enable clear uses measured voltage rms
// - Nominal voltage read with zero top byte
// - Read-clear zeroes var-hour after read, except in line-cycle mode
// - Outside line-cycle, access transfers accumulators
`timescale 1ns/10ps
`default_nettype none
`include "rap_regs.vh"
module rap_core #(
  parameter CW = 16
) (
  input wire core_clk,
  input wire nrst,
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [31:0] wr_data,
  input wire rd_en,
  input wire [7:0] rd_addr,
  output reg [31:0] rd_data,
  output reg rd_valid,
  input wire sample_strobe,
  input wire [71:0] v_inst,
  input wire [71:0] v_rms,
  input wire [71:0] i_rms,
  input wire [23:0] line_ac_rms,
  input wire [71:0] q_inst,
  input wire [2:0] p_neg,
  input wire [5:0] var_pulse,
  input wire [5:0] var_neg,
  input wire [2:0] zx_pulse,
  output reg [23:0] phase_b_v_sel,
  output reg [23:0] phase_b_voltage_rms,
  output reg [71:0] freq_var_power,
  output wire [71:0] inst_apparent_power,
  output wire [2:0] freq_out1_term_select,
  output wire line_cycle_done_flag,
  output wire irq_n
);
  function addr_hit;
    input [7:0] a;
    input [7:0] base;
    input [2:0] idx;
    begin
      addr_hit = (a == base + {5'h00, idx});
    end
  endfunction

  // Saturating 24-bit narrowing of a 26-bit signed value
  function [23:0] sat24;
    input [25:0] x;
    begin
      if (!x[25] && x[24:23] != 2'h0)
        sat24 = 24'h7FFFFF;
      else if (x[25] && x[24:23] != 2'h3)
        sat24 = 24'h800000;
      else
        sat24 = x[23:0];
    end
  endfunction

  function [23:0] neg_sat;
    input [23:0] x;
    begin
      neg_sat = sat24(26'h0 - {{2{x[23]}}, x});
    end
  endfunction

  reg [7:0] accumulation_mode_reg;
  reg [7:0] line_cycle_mode_reg;
  reg [15:0] computation_mode_reg;
  reg [CW-1:0] half_cycle_count;
  reg [31:0] irq_mask_primary;
  reg [31:0] status_reg;
  reg [71:0] gain_bus;
  reg [23:0] nominal_voltage;

  wire [1:0] wiring_config_sel;
  assign wiring_config_sel =
    accumulation_mode_reg[`RAP_WIRE_HI:`RAP_WIRE_LO];
  wire [1:0] reactive_freq_sign_mode;
  assign reactive_freq_sign_mode =
    accumulation_mode_reg[`RAP_FMODE_HI:`RAP_FMODE_LO];
  wire line_cycle_reactive_en;
  assign line_cycle_reactive_en = line_cycle_mode_reg[`RAP_LC_VAR_BIT];
  wire read_clears_energy;
  assign read_clears_energy = line_cycle_mode_reg[`RAP_RD_CLR_BIT];
  wire [2:0] zero_cross_phase_sel;
  assign zero_cross_phase_sel =
    line_cycle_mode_reg[`RAP_ZX_SEL_HI:`RAP_ZX_SEL_LO];
  wire [2:0] nom_v_en;
  assign nom_v_en = computation_mode_reg[`RAP_VNOMEN_HI:`RAP_VNOMEN_LO];
  // Phase B term bit must be cleared by software in three-wire use
  assign freq_out1_term_select =
    computation_mode_reg[`RAP_TERMSEL_HI:`RAP_TERMSEL_LO];

  // Configuration writes
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      accumulation_mode_reg <= `RAP_RST_ACC_MODE;
      line_cycle_mode_reg <= `RAP_RST_LC_MODE;
      computation_mode_reg <= `RAP_RST_COMP_MODE;
      half_cycle_count <= {CW{1'b1}};
      irq_mask_primary <= `RAP_RST_MASK;
      gain_bus <= 72'h0;
      nominal_voltage <= 24'h000000;
    end else if (wr_en) begin
      case (wr_addr)
        `RAP_ADDR_ACC_MODE: accumulation_mode_reg <= wr_data[7:0];
        `RAP_ADDR_LC_MODE: line_cycle_mode_reg <= wr_data[7:0];
        `RAP_ADDR_COMP_MODE: computation_mode_reg <= wr_data[15:0];
        `RAP_ADDR_HALFCYC: half_cycle_count <= wr_data[CW-1:0];
        `RAP_ADDR_MASK: irq_mask_primary <= wr_data;
        `RAP_ADDR_GAIN_BASE: gain_bus[23:0] <= wr_data[23:0];
        `RAP_ADDR_GAIN_BASE + 8'h01: gain_bus[47:24] <= wr_data[23:0];
        `RAP_ADDR_GAIN_BASE + 8'h02: gain_bus[71:48] <= wr_data[23:0];
        `RAP_ADDR_NOM_V: nominal_voltage <= wr_data[23:0];
        default: begin
        end
      endcase
    end
  end

  // Phase B voltage source and its rms result
  wire [23:0] va_i;
  assign va_i = v_inst[23:0];
  wire [23:0] vb_i;
  assign vb_i = v_inst[47:24];
  wire [23:0] vc_i;
  assign vc_i = v_inst[71:48];
  reg [23:0] vb_sel_next;
  always @* begin
    case (wiring_config_sel)
      `RAP_WIRE_4W:
        vb_sel_next = vb_i;
      `RAP_WIRE_3W:
        vb_sel_next = sat24({{2{va_i[23]}}, va_i} - {{2{vc_i[23]}}, vc_i});
      `RAP_WIRE_NEG_AC:
        vb_sel_next = sat24(26'h0 - {{2{va_i[23]}}, va_i}
                            - {{2{vc_i[23]}}, vc_i});
      default:
        vb_sel_next = neg_sat(va_i);
    endcase
  end

  wire [23:0] vb_rms_used;
  assign vb_rms_used = (wiring_config_sel == `RAP_WIRE_3W) ?
    line_ac_rms : v_rms[47:24];

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase_b_v_sel <= 24'h000000;
      phase_b_voltage_rms <= 24'h000000;
    end else begin
      phase_b_v_sel <= vb_sel_next;
      phase_b_voltage_rms <= vb_rms_used;
    end
  end

  // Frequency-output reactive power, per phase
  wire [71:0] fq_bus;
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_fq
      wire [23:0] q;
      assign q = q_inst[24*p +: 24];
      reg [23:0] fq_next;
      always @* begin
        case (reactive_freq_sign_mode)
          `RAP_FMODE_SIGNED: fq_next = q;
          `RAP_FMODE_SADJ: fq_next = p_neg[p] ? neg_sat(q) : q;
          `RAP_FMODE_ABS: fq_next = q[23] ? neg_sat(q) : q;
          default: fq_next = q;
        endcase
      end
      assign fq_bus[24*p +: 24] = fq_next;
    end
  endgenerate

  // One process owns the whole output, no split drivers
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      freq_var_power <= 72'h0;
    else
      freq_var_power <= fq_bus;
  end

  // Line-cycle period detection
  wire lc_done;
  rap_half_cycle_count #(
    .CW(CW)
  ) u_half_cycle_count (
    .core_clk(core_clk),
    .nrst(nrst),
    .enable(line_cycle_reactive_en),
    .zx_pulse(zx_pulse),
    .zx_sel(zero_cross_phase_sel),
    .count(half_cycle_count),
    .done(lc_done)
  );

  // Var-hour accumulators: 0..2 total A..C, 3..5 fundamental A..C
  wire [191:0] acc_bus;
  wire [191:0] res_bus;
  genvar k;
  generate
    for (k = 0; k < 6; k = k + 1) begin : g_acc
      localparam [2:0] IDX = k;
      wire [31:0] delta;
      assign delta = !var_pulse[k] ? 32'h00000000 :
        (var_neg[k] ? 32'hFFFFFFFF : 32'h00000001);
      wire hit;
      assign hit = rd_en && addr_hit(rd_addr, `RAP_ADDR_VAR_BASE, IDX);
      reg [31:0] acc_reg;
      reg [31:0] result_reg;
      always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          acc_reg <= 32'h00000000;
          result_reg <= 32'h00000000;
        end else if (line_cycle_reactive_en) begin
          // Read-clear has no effect here
          if (lc_done) begin
            result_reg <= acc_reg;
            acc_reg <= delta;
          end else begin
            acc_reg <= acc_reg + delta;
          end
        end else if (hit && read_clears_energy) begin
          // Pulse in the read cycle opens the next sum, not lost
          result_reg <= 32'h00000000;
          acc_reg <= delta;
        end else if (hit) begin
          result_reg <= acc_reg;
          acc_reg <= acc_reg + delta;
        end else begin
          acc_reg <= acc_reg + delta;
        end
      end
      assign acc_bus[32*k +: 32] = acc_reg;
      assign res_bus[32*k +: 32] = result_reg;
    end
  endgenerate

  // Status: set wins over a write-one clear
  wire [31:0] status_set;
  assign status_set = {26'h0, lc_done, 5'h00};
  wire [31:0] status_clr;
  assign status_clr = (wr_en && wr_addr == `RAP_ADDR_STATUS) ?
    wr_data : 32'h00000000;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      status_reg <= 32'h00000000;
    else
      status_reg <= (status_reg & ~status_clr) | status_set;
  end
  assign line_cycle_done_flag = status_reg[`RAP_LDONE_BIT];
  assign irq_n = ~(|(status_reg & irq_mask_primary));

  // Apparent power, per phase
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_va
      rap_vaphase u_va (
        .core_clk(core_clk),
        .nrst(nrst),
        .sample_strobe(sample_strobe),
        .nom_v_en(nom_v_en[p]),
        .v_rms(v_rms[24*p +: 24]),
        .i_rms(i_rms[24*p +: 24]),
        .nom_v(nominal_voltage),
        .gain(gain_bus[24*p +: 24]),
        .va_out(inst_apparent_power[24*p +: 24])
      );
    end
  endgenerate

  // Read mux
  reg [31:0] rd_next;
  integer j;
  always @* begin
    rd_next = 32'h00000000;
    case (rd_addr)
      `RAP_ADDR_ACC_MODE: rd_next = {24'h0, accumulation_mode_reg};
      `RAP_ADDR_LC_MODE: rd_next = {24'h0, line_cycle_mode_reg};
      `RAP_ADDR_COMP_MODE: rd_next = {16'h0, computation_mode_reg};
      `RAP_ADDR_HALFCYC: rd_next = {{(32-CW){1'b0}}, half_cycle_count};
      `RAP_ADDR_MASK: rd_next = irq_mask_primary;
      `RAP_ADDR_STATUS: rd_next = status_reg;
      `RAP_ADDR_NOM_V: rd_next = {8'h00, nominal_voltage};
      `RAP_ADDR_B_RMS: rd_next = {8'h00, phase_b_voltage_rms};
      default: begin
        for (j = 0; j < 3; j = j + 1) begin
          if (addr_hit(rd_addr, `RAP_ADDR_GAIN_BASE, j[2:0]))
            rd_next = {8'h00, gain_bus[24*j +: 24]};
          if (addr_hit(rd_addr, `RAP_ADDR_VA_BASE, j[2:0]))
            rd_next = {8'h00, inst_apparent_power[24*j +: 24]};
        end
        for (j = 0; j < 6; j = j + 1) begin
          if (addr_hit(rd_addr, `RAP_ADDR_VAR_BASE, j[2:0]))
            rd_next = line_cycle_reactive_en ?
              res_bus[32*j +: 32] : acc_bus[32*j +: 32];
        end
      end
    endcase
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 32'h00000000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en)
        rd_data <= rd_next;
    end
  end
endmodule // rap_core
`default_nettype wire

// ---- tb/rap_core_props.sv ----
// Assertion checker for the reactive mode and apparent power core
`timescale 1ns/10ps
`default_nettype none
module rap_core_props #(
  parameter CW = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic rd_valid,
  input wire logic sample_strobe,
  input wire logic [71:0] v_rms,
  input wire logic [23:0] line_ac_rms,
  input wire logic [71:0] q_inst,
  input wire logic [2:0] zx_pulse,
  input wire logic [23:0] phase_b_voltage_rms,
  input wire logic [71:0] freq_var_power,
  input wire logic [71:0] inst_apparent_power,
  input wire logic line_cycle_done_flag,
  input wire logic irq_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_RD_ANSWER: assert property (rd_en |=> rd_valid)
    else $error("read not answered next cycle");
  AST_RD_PULSE: assert property (!rd_en |=> !rd_valid)
    else $error("read valid without a read");
  AST_RD_HOLD: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read data moved between reads");
  AST_BRMS_SRC: assert property (1 |=>
    phase_b_voltage_rms == $past(line_ac_rms) ||
    phase_b_voltage_rms == $past(v_rms[47:24]))
    else $error("phase b rms from unknown source");
  AST_VA_HOLD: assert property (
    $changed(inst_apparent_power) |-> $past(sample_strobe))
    else $error("apparent power moved without strobe");
  AST_VA_POS: assert property (!inst_apparent_power[23] &&
    !inst_apparent_power[47] && !inst_apparent_power[71])
    else $error("apparent power negative");
  AST_FREQ_A: assert property (1 |=>
    freq_var_power[23:0] == $past(q_inst[23:0]) ||
    freq_var_power[23:0] == -$past(q_inst[23:0]) ||
    freq_var_power[23:0] == 24'h7FFFFF)
    else $error("frequency power not from reactive power");
  AST_DONE_CAUSE: assert property ($rose(line_cycle_done_flag) |->
    $past(zx_pulse) != 3'h0 || $past(zx_pulse, 2) != 3'h0)
    else $error("period end without zero crossing");
  AST_DONE_HOLD: assert property (
    line_cycle_done_flag && !wr_en |=> line_cycle_done_flag)
    else $error("done flag dropped without write");
  AST_IRQ_SRC: assert property (!irq_n |-> line_cycle_done_flag)
    else $error("interrupt without done flag");
endmodule // rap_core_props
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the reactive mode and apparent power core
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic core_clk = 0;
  logic nrst = 0;
  logic wr_en = 0;
  logic rd_en = 0;
  logic sample_strobe = 0;
  logic [7:0] wr_addr = 0;
  logic [7:0] rd_addr = 0;
  logic [31:0] wr_data = 0;
  logic [71:0] v_inst = 0;
  logic [71:0] v_rms = 0;
  logic [71:0] i_rms = 0;
  logic [71:0] q_inst = 0;
  logic [23:0] line_ac_rms = 0;
  logic [2:0] p_neg = 0;
  logic [2:0] zx_pulse = 0;
  logic [5:0] var_pulse = 0;
  logic [5:0] var_neg = 0;
  logic [31:0] rd_data;
  logic rd_valid;
  logic [23:0] phase_b_v_sel;
  logic [23:0] phase_b_voltage_rms;
  logic [71:0] freq_var_power;
  logic [71:0] inst_apparent_power;
  logic [2:0] freq_out1_term_select;
  logic line_cycle_done_flag;
  logic irq_n;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int a, c, vb, ib, q, e;

  always #5 core_clk = ~core_clk;

  rap_core #(.CW(16)) dut (.core_clk, .nrst, .wr_en, .wr_addr, .wr_data,
    .rd_en, .rd_addr, .rd_data, .rd_valid, .sample_strobe, .v_inst, .v_rms,
    .i_rms, .line_ac_rms, .q_inst, .p_neg, .var_pulse, .var_neg, .zx_pulse,
    .phase_b_v_sel, .phase_b_voltage_rms, .freq_var_power,
    .inst_apparent_power, .freq_out1_term_select, .line_cycle_done_flag,
    .irq_n);

  task give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Generous ceiling; the whole sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      give_verdict();
    end
  end

  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask

  // Model is real-valued; the design truncates, so allow two LSBs
  task chkn(input string n, input real x, input logic [23:0] g);
    real d;
    d = x - g;
    checks++;
    if ((^g) === 1'bx || d > 2.0 || d < -2.0) begin
      err_count++;
      $display("BAD %s expected %0d seen %h", n, $rtoi(x), g);
    end
  endtask

  function real va_m(input real v, input real i, input real g);
    real r;
    r = v * i * 33516139.0 / (4191910.0 * 4191910.0 * 16.0);
    r = r * (8388608.0 + g) / 8388608.0;
    if (r > 8388607.0) r = 8388607.0;
    return r < 0.0 ? 0.0 : r;
  endfunction

  task step(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge core_clk);
    wr_en <= 1;
    wr_addr <= ad;
    wr_data <= dt;
    @(posedge core_clk);
    wr_en <= 0;
  endtask

  task rdc(input logic [7:0] ad, input logic [31:0] x, input string n);
    @(posedge core_clk);
    rd_en <= 1;
    rd_addr <= ad;
    @(posedge core_clk);
    rd_en <= 0;
    #1;
    chk("rd_valid", 1, rd_valid);
    chk(n, x, rd_data);
  endtask

  task pulse(input int b, input logic ng, input int n);
    repeat (n) begin
      @(posedge core_clk);
      var_pulse[b] <= 1;
      var_neg[b] <= ng;
      @(posedge core_clk);
      var_pulse[b] <= 0;
    end
  endtask

  task zxp(input int p);
    @(posedge core_clk);
    zx_pulse[p] <= 1;
    @(posedge core_clk);
    zx_pulse[p] <= 0;
  endtask

  initial begin
    a = $urandom(78);
    step(6);
    nrst <= 1;
    rdc(8'h02, 32'h00000007, "computation_mode_reg");
    rdc(8'h03, 32'h0000FFFF, "halfcyc");
    rdc(8'h00, 32'h00000000, "accumulation_mode_reg");
    rdc(8'h30, 32'h00000000, "unmapped");
    chk("termsel", 32'h7, freq_out1_term_select);
    wr(8'h06, 32'hFFC00000);
    rdc(8'h06, 32'h00C00000, "gain a");
    wr(8'h09, 32'hAB1E8480);
    rdc(8'h09, 32'h001E8480, "nominal_voltage");
    $display("test registers done");
    ib = $urandom_range(4191910, 1);
    v_rms <= {24'h2DC6C0, 24'h3FF6A6, 24'h3FF6A6};
    i_rms <= {ib[23:0], 24'h3FF6A6, 24'h3FF6A6};
    wr(8'h07, 32'h00400000);
    zxp(0);
    sample_strobe <= 1;
    step(1);
    sample_strobe <= 0;
    step(3);
    chkn("va a", va_m(4191910, 4191910, -4194304),
      inst_apparent_power[23:0]);
    chkn("va b", va_m(4191910, 4191910, 4194304),
      inst_apparent_power[47:24]);
    chkn("va c", va_m(3000000, ib, 0), inst_apparent_power[71:48]);
    wr(8'h02, 32'h00001007);
    sample_strobe <= 1;
    step(1);
    sample_strobe <= 0;
    step(3);
    chkn("nominal_voltage b", va_m(2000000, 4191910, 4194304),
      inst_apparent_power[47:24]);
    wr(8'h02, 32'h00000005);
    step(1);
    chk("termsel b off", 32'h5, freq_out1_term_select);
    $display("test apparent done");
    a = $urandom_range(1000000);
    c = $urandom_range(1000000);
    vb = $urandom_range(1000000);
    v_inst <= {c[23:0], vb[23:0], a[23:0]};
    line_ac_rms <= 24'h123456;
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, k << 4);
      step(2);
      e = k == 0 ? vb : k == 1 ? a - c : k == 2 ? -a - c : -a;
      chk("b sel", e & 32'h00FFFFFF, phase_b_v_sel);
      chk("b rms", k == 1 ? 32'h123456 : 32'h3FF6A6,
        phase_b_voltage_rms);
    end
    q = -$urandom_range(100000, 1);
    q_inst <= {48'h0, q[23:0]};
    p_neg <= 3'h1;
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, k << 2);
      step(2);
      e = (k == 1 || k == 2) ? -q : q;
      chk("freq a", e & 32'h00FFFFFF, freq_var_power[23:0]);
    end
    wr(8'h00, 32'h0);
    $display("test modes done");
    pulse(0, 0, 5);
    pulse(0, 1, 2);
    pulse(4, 1, 2);
    rdc(8'h10, 32'h00000003, "varhr a");
    rdc(8'h14, 32'hFFFFFFFE, "fvarhr b");
    wr(8'h01, 32'h40);
    rdc(8'h10, 32'h00000003, "varhr clr");
    rdc(8'h10, 32'h00000000, "varhr zero");
    $display("test varhour done");
    wr(8'h01, 32'h0);
    wr(8'h03, 32'h3);
    wr(8'h04, 32'h20);
    wr(8'h01, 32'h0A);
    pulse(0, 0, 4);
    zxp(1);
    zxp(1);
    zxp(0);
    zxp(0);
    step(3);
    chk("done early", 0, line_cycle_done_flag);
    zxp(0);
    step(3);
    chk("done", 1, line_cycle_done_flag);
    chk("irq", 0, irq_n);
    rdc(8'h10, 32'h00000004, "lc varhr");
    pulse(0, 0, 1);
    rdc(8'h10, 32'h00000004, "lc held");
    wr(8'h05, 32'h20);
    step(1);
    chk("irq clr", 1, irq_n);
    $display("test line cycle done");
    give_verdict();
  end
endmodule // testbench

bind rap_core rap_core_props #(.CW(CW)) u_props (.core_clk(core_clk),
  .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .rd_valid(rd_valid), .sample_strobe(sample_strobe), .v_rms(v_rms),
  .line_ac_rms(line_ac_rms), .q_inst(q_inst), .zx_pulse(zx_pulse),
  .phase_b_voltage_rms(phase_b_voltage_rms),
  .freq_var_power(freq_var_power),
  .inst_apparent_power(inst_apparent_power),
  .line_cycle_done_flag(line_cycle_done_flag), .irq_n(irq_n));
`default_nettype wire
